/* File: design/cvr_regs.sv */
// Output ramp and DAC digital volume register bank with APB slave
`timescale 1ns/1ps
module cvr_regs
  import cvr_pkg::*;
#(
  parameter logic [CNT_W-1:0] DLY_1  = DLY_CYC_1,
  parameter logic [CNT_W-1:0] DLY_2  = DLY_CYC_2,
  parameter logic [CNT_W-1:0] DLY_3  = DLY_CYC_3,
  parameter logic [CNT_W-1:0] DLY_4  = DLY_CYC_4,
  parameter logic [CNT_W-1:0] DLY_5  = DLY_CYC_5,
  parameter logic [CNT_W-1:0] STEP_1 = STEP_CYC_1,
  parameter logic [CNT_W-1:0] STEP_2 = STEP_CYC_2,
  parameter logic [CNT_W-1:0] STEP_3 = STEP_CYC_3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output cvr_ramp_t             ramp,
  output cvr_vol_t              left_vol,
  output cvr_vol_t              right_vol
);

  // ***************************************************
  // Storage
  // ***************************************************
  logic [7:0] out_switch;
  logic [7:0] pop_reduce;
  logic [7:0] left_reg;
  logic [7:0] right_reg;
  logic       access;
  logic       wr;
  logic       hit;
  logic [7:0] rd_byte;
  logic [1:0] trk;

  assign access  = psel && penable;
  assign wr      = access && pwrite;
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign trk     = out_switch[TRK_MSB:TRK_LSB];

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      ADDR_OUT_SWITCH: rd_byte = out_switch;
      ADDR_POP_REDUCE: rd_byte = pop_reduce;
      ADDR_LEFT_VOL:   rd_byte = left_reg;
      ADDR_RIGHT_VOL:  rd_byte = right_reg;
      default:         hit     = 1'b0;
    endcase
  end

  // ***************************************************
  // Register writes
  // ***************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_switch <= RST_OUT_SWITCH;
    end else if (wr && paddr == ADDR_OUT_SWITCH) begin
      out_switch <= pwdata[7:0] & MASK_OUT_SWITCH;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pop_reduce <= RST_POP_REDUCE;
    end else if (wr && paddr == ADDR_POP_REDUCE) begin
      pop_reduce <= pwdata[7:0] & MASK_POP_REDUCE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg <= RST_VOL;
    end else if (wr && paddr == ADDR_LEFT_VOL) begin
      left_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      right_reg <= RST_VOL;
    end else if (wr && paddr == ADDR_RIGHT_VOL) begin
      right_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ***************************************************
  // Effective channel volumes
  // ***************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_vol  <= cvr_vol_t'(RST_VOL);
      right_vol <= cvr_vol_t'(RST_VOL);
    end else begin
      left_vol  <= cvr_vol_t'((trk == TRK_LEFT_FOLLOWS) ? right_reg : left_reg);
      right_vol <= cvr_vol_t'((trk == TRK_RIGHT_FOLLOWS) ? left_reg : right_reg);
    end
  end

  cvr_decode #(
    .DLY_1  (DLY_1),
    .DLY_2  (DLY_2),
    .DLY_3  (DLY_3),
    .DLY_4  (DLY_4),
    .DLY_5  (DLY_5),
    .STEP_1 (STEP_1),
    .STEP_2 (STEP_2),
    .STEP_3 (STEP_3)
  ) u_decode (
    .clk     (clk),
    .rst     (rst),
    .pop_reg (pop_reduce),
    .ramp    (ramp)
  );

  // ***************************************************
  // Assertions
  // ***************************************************
  a_left_mute_follow: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_LEFT_VOL && trk != TRK_LEFT_FOLLOWS ##1 trk != TRK_LEFT_FOLLOWS
      |=> left_vol.mute == $past(pwdata[MUTE_BIT], 2))
    else $error("left mute not applied");
  a_left_atten_follow: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_LEFT_VOL && trk != TRK_LEFT_FOLLOWS ##1 trk != TRK_LEFT_FOLLOWS
      |=> left_vol.atten == $past(pwdata[6:0], 2))
    else $error("left attenuation not applied");
  a_right_mute_follow: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_RIGHT_VOL && trk != TRK_RIGHT_FOLLOWS ##1 trk != TRK_RIGHT_FOLLOWS
      |=> right_vol.mute == $past(pwdata[MUTE_BIT], 2))
    else $error("right mute not applied");
  a_right_atten_follow: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_RIGHT_VOL && trk != TRK_RIGHT_FOLLOWS ##1 trk != TRK_RIGHT_FOLLOWS
      |=> right_vol.atten == $past(pwdata[6:0], 2))
    else $error("right attenuation not applied");
  a_left_tracks_right: assert property (@(posedge clk) disable iff (rst)
    trk == TRK_LEFT_FOLLOWS |=> left_vol == cvr_vol_t'($past(right_reg)))
    else $error("left does not follow right");
  a_right_tracks_left: assert property (@(posedge clk) disable iff (rst)
    trk == TRK_RIGHT_FOLLOWS |=> right_vol == cvr_vol_t'($past(left_reg)))
    else $error("right does not follow left");
  a_delay_from_write: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_POP_REDUCE && pwdata[7:5] == 3'h1 ##1 !(wr && paddr == ADDR_POP_REDUCE)
      |=> ramp.delay_cycles == DLY_1)
    else $error("delay code 1 not applied");
  a_unmapped_error: assert property (@(posedge clk) disable iff (rst)
    access && paddr > ADDR_RIGHT_VOL |-> pslverr && pready)
    else $error("unmapped address not refused");

  // ***************************************************
  // Storage, read path, volume and ramp checks
  // ***************************************************
  a_pop_write_store: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_POP_REDUCE
      |=> pop_reduce == $past(pwdata[7:0]))
    else $error("pop reduction write not stored");
  a_pop_read_data: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == ADDR_POP_REDUCE
      |=> prdata == {24'h00_0000, $past(pop_reduce)})
    else $error("pop reduction read data wrong");
  a_left_read_data: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == ADDR_LEFT_VOL
      |=> prdata == {24'h00_0000, $past(left_reg)})
    else $error("left volume read data wrong");
  a_right_read_data: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && paddr == ADDR_RIGHT_VOL
      |=> prdata == {24'h00_0000, $past(right_reg)})
    else $error("right volume read data wrong");
  a_switch_store: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_OUT_SWITCH
      |=> (out_switch & ~MASK_OUT_SWITCH) == 8'h00 && trk == $past(pwdata[TRK_MSB:TRK_LSB]))
    else $error("output switch write not stored");
  a_vol_independent: assert property (@(posedge clk) disable iff (rst)
    trk != TRK_LEFT_FOLLOWS && trk != TRK_RIGHT_FOLLOWS
      |=> left_vol == cvr_vol_t'($past(left_reg)) && right_vol == cvr_vol_t'($past(right_reg)))
    else $error("channels not independent");
  a_step_from_write: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_POP_REDUCE && pwdata[STEP_MSB:STEP_LSB] == 2'h2 ##1 !(wr && paddr == ADDR_POP_REDUCE)
      |=> ramp.step_cycles == STEP_2)
    else $error("step code 2 not applied");
  a_vcm_from_write: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == ADDR_POP_REDUCE ##1 !(wr && paddr == ADDR_POP_REDUCE)
      |=> ramp.vcm_bandgap == $past(pwdata[VCM_BIT], 2))
    else $error("common-mode source write not applied");
  a_unmapped_ignored: assert property (@(posedge clk) disable iff (rst)
    wr && !hit
      |=> $stable(out_switch) && $stable(pop_reduce) && $stable(left_reg) && $stable(right_reg))
    else $error("unmapped write changed a register");
  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && !pwrite && !hit
      |=> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  c_left_unmute:  cover property (@(posedge clk) disable iff (rst) !left_vol.mute);
  c_right_unmute: cover property (@(posedge clk) disable iff (rst) !right_vol.mute);
  c_track_left:   cover property (@(posedge clk) disable iff (rst) trk == TRK_LEFT_FOLLOWS);
  c_track_right:  cover property (@(posedge clk) disable iff (rst) trk == TRK_RIGHT_FOLLOWS);
  c_long_delay:   cover property (@(posedge clk) disable iff (rst) ramp.delay_cycles == DLY_5);

endmodule : cvr_regs

/* File: design/cvr_pkg.sv */
// Package with register map, field layout and timing constants of the output ramp and DAC volume block
package cvr_pkg;

  // ***************************************************
  // Register map (printed offsets not all multiples of four: index, byte = 4 * index)
  // ***************************************************
  localparam logic [7:0]  IDX_OUT_SWITCH   = 8'h29;
  localparam logic [7:0]  IDX_POP_REDUCE   = 8'h2A;
  localparam logic [7:0]  IDX_LEFT_VOL     = 8'h2B;
  localparam logic [7:0]  IDX_RIGHT_VOL    = 8'h2C;
  localparam logic [11:0] ADDR_OUT_SWITCH  = {2'h0, IDX_OUT_SWITCH, 2'h0};
  localparam logic [11:0] ADDR_POP_REDUCE  = {2'h0, IDX_POP_REDUCE, 2'h0};
  localparam logic [11:0] ADDR_LEFT_VOL    = {2'h0, IDX_LEFT_VOL, 2'h0};
  localparam logic [11:0] ADDR_RIGHT_VOL   = {2'h0, IDX_RIGHT_VOL, 2'h0};

  // ***************************************************
  // Reset values and write masks
  // ***************************************************
  localparam logic [7:0] RST_OUT_SWITCH  = 8'h00;
  localparam logic [7:0] RST_POP_REDUCE  = 8'h00;
  localparam logic [7:0] RST_VOL         = 8'h80;
  localparam logic [7:0] MASK_OUT_SWITCH = 8'hF3;
  localparam logic [7:0] MASK_POP_REDUCE = 8'hFF;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int DLY_MSB   = 7;
  localparam int DLY_LSB   = 5;
  localparam int STEP_MSB  = 3;
  localparam int STEP_LSB  = 2;
  localparam int VCM_BIT   = 1;
  localparam int MUTE_BIT  = 7;
  localparam int TRK_MSB   = 1;
  localparam int TRK_LSB   = 0;

  localparam logic [1:0] TRK_LEFT_FOLLOWS  = 2'h1;
  localparam logic [1:0] TRK_RIGHT_FOLLOWS = 2'h2;

  // ***************************************************
  // Timing in microseconds and cycle counts at 100 MHz
  // ***************************************************
  localparam longint CLK_MHZ     = 100;
  localparam longint DLY_US_1    = 100;
  localparam longint DLY_US_2    = 10000;
  localparam longint DLY_US_3    = 100000;
  localparam longint DLY_US_4    = 400000;
  localparam longint DLY_US_5    = 2000000;
  localparam longint STEP_US_1   = 1000;
  localparam longint STEP_US_2   = 2000;
  localparam longint STEP_US_3   = 4000;
  localparam int     CNT_W       = 28;
  localparam logic [CNT_W-1:0] DLY_CYC_1  = CNT_W'(DLY_US_1 * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY_CYC_2  = CNT_W'(DLY_US_2 * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY_CYC_3  = CNT_W'(DLY_US_3 * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY_CYC_4  = CNT_W'(DLY_US_4 * CLK_MHZ);
  localparam logic [CNT_W-1:0] DLY_CYC_5  = CNT_W'(DLY_US_5 * CLK_MHZ);
  localparam logic [CNT_W-1:0] STEP_CYC_1 = CNT_W'(STEP_US_1 * CLK_MHZ);
  localparam logic [CNT_W-1:0] STEP_CYC_2 = CNT_W'(STEP_US_2 * CLK_MHZ);
  localparam logic [CNT_W-1:0] STEP_CYC_3 = CNT_W'(STEP_US_3 * CLK_MHZ);

  // ***************************************************
  // Carriers
  // ***************************************************
  typedef struct packed {
    logic       mute;
    logic [6:0] atten;
  } cvr_vol_t;

  typedef struct packed {
    logic [CNT_W-1:0] delay_cycles;
    logic [CNT_W-1:0] step_cycles;
    logic             vcm_bandgap;
  } cvr_ramp_t;

endpackage : cvr_pkg

/* File: design/cvr_decode.sv */
// Decoder of delay and ramp step codes into cycle counts
`timescale 1ns/1ps
module cvr_decode
  import cvr_pkg::*;
#(
  parameter logic [CNT_W-1:0] DLY_1  = DLY_CYC_1,
  parameter logic [CNT_W-1:0] DLY_2  = DLY_CYC_2,
  parameter logic [CNT_W-1:0] DLY_3  = DLY_CYC_3,
  parameter logic [CNT_W-1:0] DLY_4  = DLY_CYC_4,
  parameter logic [CNT_W-1:0] DLY_5  = DLY_CYC_5,
  parameter logic [CNT_W-1:0] STEP_1 = STEP_CYC_1,
  parameter logic [CNT_W-1:0] STEP_2 = STEP_CYC_2,
  parameter logic [CNT_W-1:0] STEP_3 = STEP_CYC_3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [7:0]       pop_reg,
  output cvr_ramp_t             ramp
);

  cvr_ramp_t next_ramp;

  always_comb begin
    next_ramp             = '0;
    next_ramp.vcm_bandgap = pop_reg[VCM_BIT];
    case (pop_reg[DLY_MSB:DLY_LSB])
      3'h0:    next_ramp.delay_cycles = '0;
      3'h1:    next_ramp.delay_cycles = DLY_1;
      3'h2:    next_ramp.delay_cycles = DLY_2;
      3'h3:    next_ramp.delay_cycles = DLY_3;
      3'h4:    next_ramp.delay_cycles = DLY_4;
      3'h5:    next_ramp.delay_cycles = DLY_5;
      default: next_ramp.delay_cycles = '0;
    endcase
    case (pop_reg[STEP_MSB:STEP_LSB])
      2'h0:    next_ramp.step_cycles = '0;
      2'h1:    next_ramp.step_cycles = STEP_1;
      2'h2:    next_ramp.step_cycles = STEP_2;
      2'h3:    next_ramp.step_cycles = STEP_3;
      default: next_ramp.step_cycles = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp <= '0;
    end else begin
      ramp <= next_ramp;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  a_delay_code_two: assert property (@(posedge clk) disable iff (rst)
    pop_reg[DLY_MSB:DLY_LSB] == 3'h2 |=> ramp.delay_cycles == DLY_2)
    else $error("delay code 2 decoded wrongly");
  a_step_code_max: assert property (@(posedge clk) disable iff (rst)
    pop_reg[STEP_MSB:STEP_LSB] == 2'h3 |=> ramp.step_cycles == STEP_3)
    else $error("step code 3 decoded wrongly");
  a_vcm_source_sel: assert property (@(posedge clk) disable iff (rst)
    ##1 ramp.vcm_bandgap == $past(pop_reg[VCM_BIT]))
    else $error("common-mode source does not follow bit");

endmodule : cvr_decode

/* File: verif/cvr_regs_tb.sv */
// Self-checking testbench of the output ramp and DAC volume register bank
`timescale 1ns/1ps
module cvr_regs_tb
  import cvr_pkg::*;
;
  // ***************************************************
  // Signals and reference model
  // ***************************************************
  localparam int DLY_T [8]  = '{0, 3, 5, 7, 9, 11, 0, 0};
  localparam int STEP_T [4] = '{0, 2, 4, 6};
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  cvr_ramp_t   ramp;
  cvr_vol_t    left_vol;
  cvr_vol_t    right_vol;
  int          miscompares;
  int          compares;
  int          cycles;
  logic [31:0] seed;
  logic [63:0] exp_q [$];
  logic [7:0]  m_pop;
  logic [7:0]  m_left;
  logic [7:0]  m_right;
  logic [7:0]  m_sw;

  cvr_regs #(
    .DLY_1(CNT_W'(DLY_T[1])), .DLY_2(CNT_W'(DLY_T[2])), .DLY_3(CNT_W'(DLY_T[3])),
    .DLY_4(CNT_W'(DLY_T[4])), .DLY_5(CNT_W'(DLY_T[5])),
    .STEP_1(CNT_W'(STEP_T[1])), .STEP_2(CNT_W'(STEP_T[2])), .STEP_3(CNT_W'(STEP_T[3]))
  ) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ramp(ramp),
    .left_vol(left_vol), .right_vol(right_vol)
  );

  // ***************************************************
  // Clock, timeout and result watcher
  // ***************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, {pslverr, prdata}, 33'h0);
      end else begin
        chk({31'h0, pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // ***************************************************
  // Tasks
  // ***************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic err);
    exp_q.push_back({31'h0, err, 24'h0, v});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr_m(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
    case (a)
      ADDR_POP_REDUCE: m_pop = v;
      ADDR_LEFT_VOL:   m_left = v;
      ADDR_RIGHT_VOL:  m_right = v;
      ADDR_OUT_SWITCH: m_sw = v & MASK_OUT_SWITCH;
      default: ;
    endcase
  endtask : wr_m

  task automatic check_all();
    logic [7:0] el;
    logic [7:0] er;
    el = (m_sw[1:0] == TRK_LEFT_FOLLOWS) ? m_right : m_left;
    er = (m_sw[1:0] == TRK_RIGHT_FOLLOWS) ? m_left : m_right;
    rd(ADDR_POP_REDUCE, m_pop, 1'b0);
    rd(ADDR_LEFT_VOL, m_left, 1'b0);
    rd(ADDR_RIGHT_VOL, m_right, 1'b0);
    rd(ADDR_OUT_SWITCH, m_sw, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk({56'h0, left_vol}, {56'h0, el});
    chk({56'h0, right_vol}, {56'h0, er});
    chk({7'h0, ramp}, {7'h0, CNT_W'(DLY_T[m_pop[7:5]]), CNT_W'(STEP_T[m_pop[3:2]]), m_pop[1]});
  endtask : check_all

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    seed = 32'h47;
    m_pop = RST_POP_REDUCE;
    m_left = RST_VOL;
    m_right = RST_VOL;
    m_sw = RST_OUT_SWITCH;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    check_all();
    for (int d = 0; d < 6; d++) begin
      wr_m(ADDR_POP_REDUCE, {d[2:0], 1'b0, d[1:0], d[0], 1'b0});
      check_all();
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr_m(ADDR_LEFT_VOL, (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : seed[7:0]);
      wr_m(ADDR_RIGHT_VOL, (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[15:8]);
      check_all();
    end
    for (int t = 0; t < 4; t++) begin
      wr_m(ADDR_OUT_SWITCH, {6'h3F, t[1:0]});
      check_all();
    end
    rd(12'h0B4, 8'h00, 1'b1);
    wr_m(12'h0B4, 8'hFF);
    check_all();
    wrap_up();
  end
endmodule : cvr_regs_tb
